// ===== core/bpc_map.vh
// Address map, field layout and reset values of the protection bytes
`ifndef BPC_MAP_VH
`define BPC_MAP_VH

// ----------------------------------------------------------------
// Byte addresses in configuration space
// ----------------------------------------------------------------
`define BPC_ADDR_CPL        22'h300008
`define BPC_ADDR_CPH        22'h300009
`define BPC_ADDR_WPL        22'h30000A
`define BPC_ADDR_WPH        22'h30000B
`define BPC_ADDR_TRL        22'h30000C
`define BPC_ADDR_TRH        22'h30000D
`define BPC_ADDR_IDL        22'h3FFFFE
`define BPC_ADDR_IDH        22'h3FFFFF

// ----------------------------------------------------------------
// Region limits
// ----------------------------------------------------------------
`define BPC_BOOT_LAST       22'h0001FF
`define BPC_BLK_FIRST       22'h000200
`define BPC_BLK_LAST        22'h007FFF
`define BPC_BLK_LSB         13
`define BPC_CFG_FIRST       22'h300000
`define BPC_CFG_LAST        22'h3000FF
`define BPC_CFGSP_TOP       2'h3

// ----------------------------------------------------------------
// Implemented-bit masks, also the unprogrammed (erased) values
// ----------------------------------------------------------------
`define BPC_MASK_LOW        8'h0F
`define BPC_MASK_CPH        8'hC0
`define BPC_MASK_WPH        8'hE0
`define BPC_MASK_TRH        8'h40

// ----------------------------------------------------------------
// Field positions in the high bytes
// ----------------------------------------------------------------
`define BPC_BIT_EE          7
`define BPC_BIT_BOOT        6
`define BPC_BIT_CFG         5
`define BPC_CFG_SPACE_STORE_LOCK_MASK       8'h20

// ----------------------------------------------------------------
// Identification field layout
// ----------------------------------------------------------------
`define BPC_ID_LOW_W        3
`define BPC_STEP_W          5
`define BPC_PART_W          11
`define BPC_ZERO_BYTE       8'h00

`endif

// ===== core/bpc_region.v
// Address region decoder for the protected program blocks
`timescale 1ns/1ps
`include "bpc_map.vh"

module bpc_region #(
  parameter NUM_BLOCKS = 4
) (
  input  wire [21:0]           addr,
  output wire                  in_boot,
  output wire [NUM_BLOCKS-1:0] in_block,
  output wire                  in_cfg
);

  wire in_prog;

  // ----------------------------------------------------------------
  // Region compare
  // ----------------------------------------------------------------
  assign in_boot = (addr <= `BPC_BOOT_LAST);
  assign in_prog = (addr >= `BPC_BLK_FIRST) && (addr <= `BPC_BLK_LAST);
  assign in_cfg  = (addr >= `BPC_CFG_FIRST) && (addr <= `BPC_CFG_LAST);

  // One 8 KB block per index; block 0 starts after the boot region
  genvar i;
  generate
    for (i = 0; i < NUM_BLOCKS; i = i + 1)
    begin : g_blk
      assign in_block[i] = in_prog &&
        ({30'h0, addr[`BPC_BLK_LSB+1:`BPC_BLK_LSB]} == i);
    end
  endgenerate

endmodule

// ===== core/bpc_top.v
// Block protection configuration bytes and access checker
`timescale 1ns/1ps
`include "bpc_map.vh"

module bpc_top #(
  parameter NUM_BLOCKS   = 4,
  parameter [10:0] PART_CODE    = 11'h2A6,  // Arbitrary value
  parameter [4:0]  SILICON_STEP = 5'h03     // Arbitrary value
) (
  input  wire                  ref_clk,
  input  wire                  reset,
  input  wire                  tbl_rd_req,
  input  wire                  tbl_wr_req,
  input  wire [21:0]           tbl_addr,
  input  wire                  tbl_ee_sel,
  input  wire [7:0]            tbl_wr_data,
  input  wire [21:0]           exec_addr,
  input  wire                  user_mode,
  input  wire [7:0]            mem_rd_data,
  output reg  [7:0]            tbl_rd_data_reg,
  output reg                   tbl_rd_valid_reg,
  output reg                   tbl_rd_blocked_reg,
  output reg                   tbl_wr_done_reg,
  output reg                   tbl_wr_refused_reg,
  output reg                   mem_wr_grant_reg,
  output wire [NUM_BLOCKS-1:0] code_lock_block,
  output wire                  eeprom_code_lock,
  output wire                  boot_code_lock,
  output wire [NUM_BLOCKS-1:0] flash_store_lock_block,
  output wire                  eeprom_store_lock,
  output wire                  boot_store_lock,
  output wire                  cfg_space_store_lock,
  output wire [NUM_BLOCKS-1:0] table_read_guard_block,
  output wire                  boot_table_read_guard
);

  // ----------------------------------------------------------------
  // Protection bytes, stored with unimplemented bits held at 0
  // ----------------------------------------------------------------
  reg  [7:0]            code_protect_low_reg;
  reg  [7:0]            code_protect_high_reg;
  reg  [7:0]            write_protect_low_reg;
  reg  [7:0]            write_protect_high_reg;
  reg  [7:0]            read_protect_low_reg;
  reg  [7:0]            read_protect_high_reg;

  wire                  tgt_boot;
  wire [NUM_BLOCKS-1:0] tgt_block;
  wire                  tgt_cfg;
  wire                  exe_boot;
  wire [NUM_BLOCKS-1:0] exe_block;
  wire                  tgt_cfgsp;
  wire                  tgt_prog;
  wire [7:0]            part_ident_low;
  wire [7:0]            part_ident_high;
  // Per-region protection verdicts, 1 means the access is hit
  wire [NUM_BLOCKS-1:0] blk_code_hit;
  wire [NUM_BLOCKS-1:0] blk_guard_hit;
  wire [NUM_BLOCKS-1:0] blk_store_hit;
  wire                  boot_code_hit;
  wire                  boot_guard_hit;
  wire                  boot_store_hit;
  wire                  ee_code_hit;
  wire                  ee_store_hit;
  wire                  cfg_store_hit;
  wire                  cfg_wr_ok;

  reg  [7:0]            rd_data_next;
  reg                   rd_block_next;
  reg                   wr_refuse_next;
  reg  [7:0]            wr_keep;
  reg                   code_block;
  reg                   guard_block;

  // ----------------------------------------------------------------
  // Region decode of target and executing code
  // ----------------------------------------------------------------
  bpc_region #(
    .NUM_BLOCKS (NUM_BLOCKS)
  ) u_tgt (
    .addr     (tbl_addr),
    .in_boot  (tgt_boot),
    .in_block (tgt_block),
    .in_cfg   (tgt_cfg)
  );

  bpc_region #(
    .NUM_BLOCKS (NUM_BLOCKS)
  ) u_exe (
    .addr     (exec_addr),
    .in_boot  (exe_boot),
    .in_block (exe_block),
    .in_cfg   ()
  );

  assign tgt_cfgsp = (tbl_addr[21:20] == `BPC_CFGSP_TOP);
  assign tgt_prog  = tgt_boot | (|tgt_block);

  // Ident bytes sit outside the config range, so they never land here
  assign cfg_wr_ok = tbl_wr_req & ~tbl_ee_sel & tgt_cfg & ~wr_refuse_next;

  // ----------------------------------------------------------------
  // Identification bytes, fixed at build time
  // ----------------------------------------------------------------
  assign part_ident_low  = {PART_CODE[`BPC_ID_LOW_W-1:0],
                            SILICON_STEP};
  assign part_ident_high = PART_CODE[`BPC_PART_W-1:`BPC_ID_LOW_W];

  // ----------------------------------------------------------------
  // Lock outputs straight from the stored bytes, 0 means protected
  // ----------------------------------------------------------------
  assign code_lock_block        = code_protect_low_reg[NUM_BLOCKS-1:0];
  assign eeprom_code_lock       = code_protect_high_reg[`BPC_BIT_EE];
  assign boot_code_lock         = code_protect_high_reg[`BPC_BIT_BOOT];
  assign flash_store_lock_block = write_protect_low_reg[NUM_BLOCKS-1:0];
  assign eeprom_store_lock      = write_protect_high_reg[`BPC_BIT_EE];
  assign boot_store_lock        = write_protect_high_reg[`BPC_BIT_BOOT];
  assign cfg_space_store_lock   = write_protect_high_reg[`BPC_BIT_CFG];
  assign table_read_guard_block = read_protect_low_reg[NUM_BLOCKS-1:0];
  assign boot_table_read_guard  = read_protect_high_reg[`BPC_BIT_BOOT];

  // ----------------------------------------------------------------
  // Per-block verdicts, one slice per program block
  // ----------------------------------------------------------------
  // Each slice only fires for the block the target address is in,
  // so an OR over the slices gives the verdict for any block.
  genvar b;
  generate
    for (b = 0; b < NUM_BLOCKS; b = b + 1)
    begin : g_verdict
      // Programming-port read of a code-locked block
      assign blk_code_hit[b]  = tgt_block[b] &
                                ~code_protect_low_reg[b];
      // Read of a guarded block by code running outside it
      assign blk_guard_hit[b] = tgt_block[b] & ~exe_block[b] &
                                ~read_protect_low_reg[b];
      // Store verdicts bind user code and programming port alike
      assign blk_store_hit[b] = tgt_block[b] &
                                ~write_protect_low_reg[b];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Single-region verdicts: boot region, data EEPROM, config bytes
  // ----------------------------------------------------------------
  assign boot_code_hit  = tgt_boot &
                          ~code_protect_high_reg[`BPC_BIT_BOOT];
  // Code inside the boot region may always read itself
  assign boot_guard_hit = tgt_boot & ~exe_boot &
                          ~read_protect_high_reg[`BPC_BIT_BOOT];
  assign boot_store_hit = tgt_boot &
                          ~write_protect_high_reg[`BPC_BIT_BOOT];
  // EEPROM verdicts ignore the address; the select alone picks them
  assign ee_code_hit    = ~code_protect_high_reg[`BPC_BIT_EE];
  assign ee_store_hit   = ~write_protect_high_reg[`BPC_BIT_EE];
  assign cfg_store_hit  = ~write_protect_high_reg[`BPC_BIT_CFG];

  // ----------------------------------------------------------------
  // Read path: protection verdict and byte selection
  // ----------------------------------------------------------------
  // Code protection guards against the programming port only, the
  // table-read guard against user code in a different block.
  always @*
  begin
    code_block  = ~user_mode &
                  ((|blk_code_hit) | boot_code_hit);
    guard_block = user_mode &
                  ((|blk_guard_hit) | boot_guard_hit);
    rd_block_next = 1'b0;
    rd_data_next  = `BPC_ZERO_BYTE;
    if (tbl_ee_sel)
    begin
      rd_block_next = ~user_mode &
                      ee_code_hit;
      rd_data_next  = mem_rd_data;
    end
    else if (tgt_cfgsp)
    begin
      // Unimplemented positions are stored as 0 and so read as 0
      case (tbl_addr)
        `BPC_ADDR_CPL: rd_data_next = code_protect_low_reg;
        `BPC_ADDR_CPH: rd_data_next = code_protect_high_reg;
        `BPC_ADDR_WPL: rd_data_next = write_protect_low_reg;
        `BPC_ADDR_WPH: rd_data_next = write_protect_high_reg;
        `BPC_ADDR_TRL: rd_data_next = read_protect_low_reg;
        `BPC_ADDR_TRH: rd_data_next = read_protect_high_reg;
        `BPC_ADDR_IDL: rd_data_next = part_ident_low;
        `BPC_ADDR_IDH: rd_data_next = part_ident_high;
        default:       rd_data_next = `BPC_ZERO_BYTE;
      endcase
    end
    else
    begin
      rd_block_next = code_block | guard_block;
      rd_data_next  = mem_rd_data;
    end
    if (rd_block_next)
      rd_data_next = `BPC_ZERO_BYTE;
  end

  // ----------------------------------------------------------------
  // Write path: verdict and the user-mode hold on the config lock
  // ----------------------------------------------------------------
  always @*
  begin
    wr_keep = `BPC_ZERO_BYTE;
    if (tbl_ee_sel)
      wr_refuse_next = ee_store_hit;
    else if (tgt_cfg)
      wr_refuse_next = cfg_store_hit;
    else if (tgt_cfgsp)
      wr_refuse_next = 1'b1;   // Ident and other config bytes fixed
    else
      wr_refuse_next =
        (|blk_store_hit) |
        boot_store_hit;
    // User code may not move the config lock; ones in keep hold it
    if (user_mode && (tbl_addr == `BPC_ADDR_WPH))
      wr_keep = `BPC_CFG_SPACE_STORE_LOCK_MASK;
  end

  // ----------------------------------------------------------------
  // Answer registers, one cycle after each request
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      tbl_rd_data_reg    <= `BPC_ZERO_BYTE;
      tbl_rd_valid_reg   <= 1'b0;
      tbl_rd_blocked_reg <= 1'b0;
      tbl_wr_done_reg    <= 1'b0;
      tbl_wr_refused_reg <= 1'b0;
      mem_wr_grant_reg   <= 1'b0;
    end
    else
    begin
      tbl_rd_valid_reg   <= tbl_rd_req;
      tbl_rd_blocked_reg <= tbl_rd_req & rd_block_next;
      tbl_rd_data_reg    <= tbl_rd_req ? rd_data_next : `BPC_ZERO_BYTE;
      tbl_wr_done_reg    <= tbl_wr_req;
      tbl_wr_refused_reg <= tbl_wr_req & wr_refuse_next;
      // Flash and EEPROM datapaths act only on a granted write
      mem_wr_grant_reg   <= tbl_wr_req & ~wr_refuse_next &
                            (tbl_ee_sel | (~tgt_cfgsp & ~tgt_prog) |
                             tgt_prog);
    end
  end

  // ----------------------------------------------------------------
  // Protection bytes: reset models the erased part, writes only clear
  // ----------------------------------------------------------------
  // AND with old value means a 1 in the data never re-arms a bit;
  // only an erase (reset here) brings a bit back to unprogrammed.
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      code_protect_low_reg   <= `BPC_MASK_LOW;
      code_protect_high_reg  <= `BPC_MASK_CPH;
      write_protect_low_reg  <= `BPC_MASK_LOW;
      write_protect_high_reg <= `BPC_MASK_WPH;
      read_protect_low_reg   <= `BPC_MASK_LOW;
      read_protect_high_reg  <= `BPC_MASK_TRH;
    end
    else if (cfg_wr_ok)
    begin
      case (tbl_addr)
        `BPC_ADDR_CPL:
          code_protect_low_reg <= code_protect_low_reg & tbl_wr_data;
        `BPC_ADDR_CPH:
          code_protect_high_reg <= code_protect_high_reg & tbl_wr_data;
        `BPC_ADDR_WPL:
          write_protect_low_reg <= write_protect_low_reg & tbl_wr_data;
        `BPC_ADDR_WPH:
          write_protect_high_reg <= write_protect_high_reg &
                                    (tbl_wr_data | wr_keep);
        `BPC_ADDR_TRL:
          read_protect_low_reg <= read_protect_low_reg & tbl_wr_data;
        `BPC_ADDR_TRH:
          read_protect_high_reg <= read_protect_high_reg & tbl_wr_data;
        default:
          code_protect_low_reg <= code_protect_low_reg;
      endcase
    end
  end

endmodule

// ===== testbench/bpc_assertions.sv
// Concurrent checks on the ports of the protection configuration block
`timescale 1ns/1ps
module bpc_checker #(
  parameter NUM_BLOCKS = 4
) (
  input wire                  ref_clk,
  input wire                  reset,
  input wire                  tbl_rd_req,
  input wire                  tbl_wr_req,
  input wire [21:0]           tbl_addr,
  input wire                  tbl_ee_sel,
  input wire [21:0]           exec_addr,
  input wire                  user_mode,
  input wire [7:0]            tbl_rd_data_reg,
  input wire                  tbl_rd_valid_reg,
  input wire                  tbl_rd_blocked_reg,
  input wire                  tbl_wr_done_reg,
  input wire                  tbl_wr_refused_reg,
  input wire                  mem_wr_grant_reg,
  input wire [NUM_BLOCKS-1:0] code_lock_block,
  input wire                  eeprom_store_lock,
  input wire                  cfg_space_store_lock,
  input wire [NUM_BLOCKS-1:0] table_read_guard_block,
  input wire                  boot_table_read_guard
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Block code, EEPROM store, config store and block guard bits gathered so one check catches any of them going back to 1
  wire [2*NUM_BLOCKS+1:0] locks = {code_lock_block, eeprom_store_lock,
    cfg_space_store_lock, table_read_guard_block};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rd_answer: assert property (tbl_rd_req |=> tbl_rd_valid_reg)
    else $error("read answer missing one cycle after request");
  a_wr_answer: assert property (tbl_wr_req |=> tbl_wr_done_reg)
    else $error("write done missing one cycle after request");
  a_done_only_req: assert property (!tbl_wr_req |=> !tbl_wr_done_reg)
    else $error("write done without a request");
  a_blocked_zero: assert property (tbl_rd_blocked_reg |->
    tbl_rd_valid_reg && tbl_rd_data_reg == 8'h00)
    else $error("blocked read returned data");
  a_ee_wr_refused: assert property (tbl_wr_req && tbl_ee_sel &&
    !eeprom_store_lock |=> tbl_wr_refused_reg && !mem_wr_grant_reg)
    else $error("locked eeprom write not refused");
  a_cfg_lock_kept: assert property (tbl_wr_req && user_mode |=>
    $stable(cfg_space_store_lock))
    else $error("user code changed config write lock");
  a_bits_clear_only: assert property ((locks & ~$past(locks)) == 0)
    else $error("protection bit returned to 1");
  a_block_guard: assert property (tbl_rd_req && user_mode &&
    !tbl_ee_sel && tbl_addr >= 22'h000200 && tbl_addr <= 22'h001FFF &&
    !table_read_guard_block[0] && exec_addr[21:13] != 9'h000
    |=> tbl_rd_blocked_reg)
    else $error("guarded block read from other block not blocked");
  a_boot_guard: assert property (tbl_rd_req && user_mode &&
    !tbl_ee_sel && tbl_addr <= 22'h0001FF && !boot_table_read_guard &&
    exec_addr >= 22'h000200 |=> tbl_rd_blocked_reg)
    else $error("guarded boot read from other block not blocked");

  // Main scenarios reached
  c_rd_blocked: cover property (tbl_rd_blocked_reg);
  c_wr_refused: cover property (tbl_wr_refused_reg);
  c_wr_granted: cover property (tbl_wr_done_reg && mem_wr_grant_reg);
endmodule

// ===== testbench/bpc_mem_model.sv
// Flash and EEPROM contents seen by table reads
`timescale 1ns/1ps
module bpc_mem_model (
  input  wire [21:0] tbl_addr,
  input  wire        tbl_ee_sel,
  output wire [7:0]  mem_rd_data
);
  // Flash data address-dependent, EEPROM 8'hA7; zero only if addr[7:0]^addr[15:8] is 8'h5C, so a forced zero shows
  assign mem_rd_data = tbl_ee_sel ? 8'hA7 :
    (tbl_addr[7:0] ^ tbl_addr[15:8] ^ 8'h5C);
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the protection configuration bytes
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam [10:0] PC = 11'h1B6;  // Arbitrary value
  localparam [4:0]  ST = 5'h0A;    // Arbitrary value
  localparam [47:0] ERASED = 48'h0FC00FE00F40;
  localparam [0:0]  N = 1'b0, Y = 1'b1;
  localparam [7:0]  ZB = 8'h00;
  localparam [21:0] ZA = 22'h0;
  reg         ref_clk, reset, tbl_rd_req, tbl_wr_req, tbl_ee_sel, user_mode;
  reg  [21:0] tbl_addr, exec_addr;
  reg  [7:0]  tbl_wr_data;
  wire [7:0]  mem_rd_data, rd_d;
  wire        rd_v, rd_b, wr_d, wr_r, wr_g, ee_c, bt_c, ee_s, bt_s, cf_s, bt_g;
  wire [3:0]  cl, sl, gd;
  integer     failures, n_tests, i;

  bpc_top #(.PART_CODE(PC), .SILICON_STEP(ST)) u_dut (.ref_clk(ref_clk),
    .reset(reset), .tbl_rd_req(tbl_rd_req), .tbl_wr_req(tbl_wr_req),
    .tbl_addr(tbl_addr), .tbl_ee_sel(tbl_ee_sel), .tbl_wr_data(tbl_wr_data),
    .exec_addr(exec_addr), .user_mode(user_mode), .mem_rd_data(mem_rd_data),
    .tbl_rd_data_reg(rd_d), .tbl_rd_valid_reg(rd_v),
    .tbl_rd_blocked_reg(rd_b), .tbl_wr_done_reg(wr_d),
    .tbl_wr_refused_reg(wr_r), .mem_wr_grant_reg(wr_g),
    .code_lock_block(cl), .eeprom_code_lock(ee_c), .boot_code_lock(bt_c),
    .flash_store_lock_block(sl), .eeprom_store_lock(ee_s),
    .boot_store_lock(bt_s), .cfg_space_store_lock(cf_s),
    .table_read_guard_block(gd), .boot_table_read_guard(bt_g));
  bpc_mem_model u_mem (.tbl_addr(tbl_addr), .tbl_ee_sel(tbl_ee_sel),
    .mem_rd_data(mem_rd_data));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Compare and count
  task chk(input [11:0] s, input [11:0] x);
    begin
      n_tests = n_tests + 1;
      if (s !== x)
      begin
        failures = failures + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  // Table read; one idle cycle between calls keeps the pulse clean
  task rd(input [21:0] a, input e, input u, input [21:0] x, input b,
          input [7:0] ex);
    reg [7:0] m;
    begin
      @(negedge ref_clk);
      tbl_addr = a; tbl_ee_sel = e; user_mode = u; exec_addr = x;
      tbl_rd_req = 1'b1;
      #1 m = (e || a[21:20] != 2'h3) ? mem_rd_data : ex;
      @(negedge ref_clk);
      tbl_rd_req = 1'b0;
      chk({2'h0, rd_b, rd_v, rd_d}, {2'h0, b, 1'b1, b ? 8'h00 : m});
    end
  endtask
  // Table write; grant only for memory targets that are allowed
  task wr(input [21:0] a, input e, input u, input [7:0] d, input r);
    begin
      @(negedge ref_clk);
      tbl_addr = a; tbl_ee_sel = e; user_mode = u; tbl_wr_data = d;
      tbl_wr_req = 1'b1;
      @(negedge ref_clk);
      tbl_wr_req = 1'b0;
      chk({9'h0, wr_d, wr_r, wr_g},
          {9'h0, 1'b1, r, !r && (e || a[21:20] != 2'h3)});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    reset = 1'b1; tbl_rd_req = 1'b0; tbl_wr_req = 1'b0; tbl_ee_sel = 1'b0;
    user_mode = 1'b0; tbl_addr = 22'h0; exec_addr = 22'h0;
    tbl_wr_data = 8'h00; failures = 0; n_tests = 0;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    for (i = 0; i < 6; i = i + 1)
      rd(22'h300008 + i[21:0], N, N, ZA, N, ERASED[47-8*i -: 8]);
    rd(22'h3FFFFE, N, N, ZA, N, {PC[2:0], ST});
    rd(22'h3FFFFF, N, N, ZA, N, PC[10:3]);
    wr(22'h3FFFFE, N, N, 8'h00, Y);
    wr(22'h300008, N, N, 8'hFE, N);
    chk({8'h0, cl}, 12'h00E);
    wr(22'h300008, N, N, 8'hFF, N);
    rd(22'h300008, N, N, ZA, N, 8'h0E);
    rd(22'h000300, N, N, ZA, Y, ZB);
    rd(22'h002100, N, N, ZA, N, ZB);
    wr(22'h300009, N, N, 8'h3F, N);
    rd(22'h300009, N, N, ZA, N, 8'h00);
    rd(22'h0, Y, N, ZA, Y, ZB);
    rd(22'h000100, N, N, ZA, Y, ZB);
    wr(22'h0, Y, Y, 8'h12, N);
    wr(22'h30000A, N, N, 8'hFD, N);
    wr(22'h002100, N, Y, 8'h34, Y);
    wr(22'h004100, N, Y, 8'h56, N);
    wr(22'h30000B, N, N, 8'h3F, N);
    rd(22'h30000B, N, N, ZA, N, 8'h20);
    wr(22'h0, Y, Y, 8'h12, Y);
    wr(22'h000100, N, Y, 8'h78, Y);
    wr(22'h30000B, N, Y, 8'h00, N);
    rd(22'h30000B, N, N, ZA, N, 8'h20);
    wr(22'h30000C, N, N, 8'hFE, N);
    wr(22'h30000D, N, N, 8'h00, N);
    chk({5'h0, gd, bt_g, ee_c, bt_c}, 12'h070);
    rd(22'h000300, N, Y, 22'h002000, Y, ZB);
    rd(22'h000300, N, Y, 22'h000400, N, ZB);
    rd(22'h000010, N, Y, 22'h002000, Y, ZB);
    rd(22'h000020, N, Y, 22'h000010, N, ZB);
    wr(22'h30000B, N, N, 8'h00, N);
    chk({5'h0, sl, bt_s, ee_s, cf_s}, 12'h068);
    wr(22'h30000C, N, N, 8'h00, Y);
    rd(22'h30000C, N, N, ZA, N, 8'h0E);
    rd(22'h300000, N, N, ZA, N, 8'h00);
    // Erase in mid-run brings every lock back to unprogrammed
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rd(22'h30000B, N, N, ZA, N, 8'hE0);
    rd(22'h30000D, N, N, ZA, N, 8'h40);
    report_and_stop;
  end
endmodule

bind bpc_top bpc_checker #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .tbl_rd_req(tbl_rd_req),
  .tbl_wr_req(tbl_wr_req), .tbl_addr(tbl_addr), .tbl_ee_sel(tbl_ee_sel),
  .exec_addr(exec_addr), .user_mode(user_mode),
  .tbl_rd_data_reg(tbl_rd_data_reg), .tbl_rd_valid_reg(tbl_rd_valid_reg),
  .tbl_rd_blocked_reg(tbl_rd_blocked_reg),
  .tbl_wr_done_reg(tbl_wr_done_reg), .mem_wr_grant_reg(mem_wr_grant_reg),
  .tbl_wr_refused_reg(tbl_wr_refused_reg),
  .code_lock_block(code_lock_block), .eeprom_store_lock(eeprom_store_lock),
  .cfg_space_store_lock(cfg_space_store_lock),
  .table_read_guard_block(table_read_guard_block),
  .boot_table_read_guard(boot_table_read_guard));
